/* File: logic/port_defines.svh */
// Register offsets, reset values and timing counts of the port latch block.
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

// Special function register addresses of the five port latches.
`define PORT_ZERO_ADDR  8'h80
`define PORT_ONE_ADDR   8'h90
`define PORT_TWO_ADDR   8'hA0
`define PORT_THREE_ADDR 8'hB0
`define PORT_FOUR_ADDR  8'hC0

// Every latch bit comes out of reset as a one.
`define LATCH_RST       8'hFF

// Strong boost length in oscillator periods, and the same in clk cycles.
`define BOOST_PERIODS   2
`define CLK_PER_OSC     1
`define BOOST_CYCLES    (`BOOST_PERIODS * `CLK_PER_OSC)

`endif

/* File: logic/port_pkg.sv */
// Types shared by the port latch block and its pin cells.
package port_pkg;

  // One port worth of bits.
  typedef logic [7:0] byte_t;

  // All five ports side by side, port 0 at index 0.
  typedef byte_t [4:0] port_bytes_t;

  // Drive controls of one port's eight pins.
  typedef struct packed {
    byte_t o;       // Level offered to the pin.
    byte_t oe_n;    // Low while the pin is driven strongly.
    byte_t boost;   // Strong boost pull-up on.
    byte_t keeper;  // Weak keeper pull-up on.
    byte_t vweak;   // Very weak pull-up on.
  } pin_ctrl_t;

  // Pin controls of all five ports.
  typedef pin_ctrl_t [4:0] port_ctrl_t;

  // Whole state of one pin cell.
  typedef struct packed {
    byte_t           prev;  // Effective level of the last cycle.
    logic [7:0][1:0] cnt;   // Boost cycles still to run per pin.
    pin_ctrl_t       ctrl;  // Registered pin controls.
  } cell_state_t;

  // Whole state of the latch block.
  typedef struct packed {
    port_bytes_t latch;  // The five port latches.
    byte_t       rdata;  // Registered read answer.
    logic        rvalid; // Read answer valid.
  } latch_state_t;

endpackage : port_pkg

/* File: logic/port_pin_cell.sv */
// Pin driver cell of one 8-bit port: effective level, pull-down and pull-ups.
`timescale 1ns/10ps
`include "port_defines.svh"

module port_pin_cell
  import port_pkg::*;
#(
  parameter bit HAS_PULLUP = 1'b1,  // Quasi-bidirectional port with pull-ups.
  parameter bit HAS_BUS    = 1'b0   // Port can carry the memory bus.
) (
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      ce,
  input  wire byte_t     latch,
  input  wire byte_t     alt_out,
  input  wire logic      bus_en,
  input  wire byte_t     bus_data,
  input  wire byte_t     pin_in,
  output pin_ctrl_t      ctrl
);

  // Reset controls: pins released high, very weak pull-up on where present.
  localparam pin_ctrl_t CTRL_RST = '{o: 8'hFF, oe_n: 8'hFF, boost: 8'h00,
                                     keeper: 8'h00,
                                     vweak: (HAS_PULLUP ? 8'hFF : 8'h00)};

  cell_state_t q;     // Registered state.
  cell_state_t d;     // Next state.
  logic        bus_w; // Memory bus owns this port.
  byte_t       eff_w; // Effective output level.
  byte_t       rise_w; // Zero-to-one step of the effective level.

  // The bus only counts on ports that can carry it.
  assign bus_w = HAS_BUS && bus_en;

  // Bus data replace the latch during memory cycles; otherwise latch and alternate output combine.
  assign eff_w = bus_w ? bus_data : (latch & alt_out);  // RULE4 RULE5 RULE3
  assign rise_w = eff_w & ~q.prev;

  // Next state: pull-down, boost counter and pull-up controls per pin.
  always_comb begin
    d = q;
    d.prev = eff_w;
    for (int i = 0; i < 8; i++) begin
      // Boost count restarts on every rise on ports with pull-ups and runs down otherwise.
      if (HAS_PULLUP && rise_w[i]) begin
        d.cnt[i] = 2'(`BOOST_CYCLES);  // RULE14
      end else if (q.cnt[i] != 2'h0) begin
        d.cnt[i] = q.cnt[i] - 2'h1;
      end else begin
        d.cnt[i] = 2'h0;
      end
    end
    d.ctrl.o = eff_w;  // RULE1
    // Strong pull-up: bus ones on bus ports, else the timed boost on ports with pull-ups.
    if (bus_w) begin
      d.ctrl.boost = bus_data;  // RULE6 RULE8
    end else if (HAS_PULLUP) begin
      // The boost is cut short when the level drops again, so it never fights the pull-down.
      for (int i = 0; i < 8; i++) begin
        d.ctrl.boost[i] = eff_w[i] && (d.cnt[i] != 2'h0);  // RULE14
      end
    end else begin
      d.ctrl.boost = 8'h00;  // RULE6
    end
    // Pull-down only for a zero; a one releases the pin for input except while boosted or driving bus ones.
    d.ctrl.oe_n = ~(~eff_w | d.ctrl.boost);  // RULE18 RULE2 RULE12
    // Keeper follows the pin level; very weak pull-up follows an idle pull-down.
    d.ctrl.keeper = HAS_PULLUP ? pin_in : 8'h00;  // RULE15 RULE7
    d.ctrl.vweak = HAS_PULLUP ? eff_w : 8'h00;  // RULE16 RULE7
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{prev: `LATCH_RST, cnt: '0, ctrl: CTRL_RST};
    end else if (ce) begin
      q <= d;
    end
  end

  assign ctrl = q.ctrl;

  // On a port with pull-ups, a rise outside bus cycles boosts for two cycles, then stops.
  property p_boost;
    @(posedge clk) disable iff (!nrst)
      (ce && !bus_w && HAS_PULLUP && rise_w[0]) ##1 (ce && !bus_w && eff_w[0])
      ##1 (ce && !bus_w && !rise_w[0])
      |-> ($past(ctrl.boost[0], 1) && ctrl.boost[0]) ##1 !ctrl.boost[0];
  endproperty
  a_boost: assert property (p_boost) else $error("boost length wrong"); // RULE14

  // The very weak pull-up is on exactly when the pull-down is off.
  property p_vweak;
    @(posedge clk) disable iff (!nrst)
      HAS_PULLUP && $past(ce) |-> ctrl.vweak == ($past(eff_w));
  endproperty
  a_vweak: assert property (p_vweak) else $error("very weak pull-up wrong"); // RULE16

  // The port without pull-ups never turns a keeper on.
  property p_float;
    @(posedge clk) disable iff (!nrst)
      !HAS_PULLUP |-> (ctrl.keeper == 8'h00) && (ctrl.vweak == 8'h00);
  endproperty
  a_float: assert property (p_float) else $error("port 0 pulled up"); // RULE7

  // Without pull-ups the strong pull-up is used only for bus ones.
  property p_open_drain;
    @(posedge clk) disable iff (!nrst)
      !HAS_PULLUP && ce && !bus_w |=> ctrl.boost == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("port 0 pulled up outside bus"); // RULE6

endmodule : port_pin_cell

/* File: logic/port_latches.sv */
// Five 8-bit port latches with register access and quasi-bidirectional pin control.
`timescale 1ns/10ps
`include "port_defines.svh"

// Contract
// RULE1: latch write sets output level of pin
// RULE2: latch one turns strong pull-down off
// RULE3: latch one lets alternate output rule
// RULE4: bus data drive ports 0, 2
// RULE5: bus ports unavailable for general I/O
// RULE6: port 0 pull-up only for bus ones
// RULE7: port 0 inputs float, no pull-ups
// RULE8: port 2 boosts bus ones
// RULE9: read-modify-write reads the latch
// RULE10: bit ops rewrite whole latch byte
// RULE11: reset loads ones into every latch
// RULE12: writing one returns pin to input
// RULE13: latch updates, pins follow next cycle
// RULE14: rise boosts exactly two oscillator periods
// RULE15: pin high turns weak keeper on
// RULE16: very weak pull-up when pull-down off
// RULE17: plain read returns pin level
// RULE18: pull-down only when effective value zero
module port_latches
  import port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire byte_t       sfr_addr,
  input  wire logic        sfr_wr,
  input  wire byte_t       sfr_wdata,
  input  wire logic        sfr_bit_wr,
  input  wire logic [2:0]  sfr_bit_sel,
  input  wire logic        sfr_bit_val,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_rmw,
  output byte_t            sfr_rdata,
  output logic             sfr_rvalid,
  output logic             sfr_hit,
  input  wire port_bytes_t alt_out,
  input  wire logic        bus_en,
  input  wire byte_t       bus_ad_lo,
  input  wire byte_t       bus_addr_hi,
  input  wire port_bytes_t pin_in,
  output port_bytes_t      latch_out,
  output port_ctrl_t       pin_ctrl
);

  // Register address of each port, port 0 first.
  localparam byte_t PORT_ADDR [5] = '{`PORT_ZERO_ADDR, `PORT_ONE_ADDR,
                                      `PORT_TWO_ADDR, `PORT_THREE_ADDR,
                                      `PORT_FOUR_ADDR};

  latch_state_t q;       // Registered state of the block.
  latch_state_t d;       // Next state of the block.
  logic [4:0]   sel_w;   // One-hot port select from the address.

  // Address decode: at most one port matches any address.
  always_comb begin
    sel_w = 5'h00;
    for (int p = 0; p < 5; p++) begin
      sel_w[p] = (sfr_addr == PORT_ADDR[p]);
    end
  end

  // A request touches this block only at one of the five addresses.
  assign sfr_hit = |sel_w;

  // Next state: latch writes, single-bit rewrites and the read answer.
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.rdata = 8'h00;
    for (int p = 0; p < 5; p++) begin
      if (sel_w[p]) begin
        // A byte write stores the value, a one making the pin an input again.
        if (sfr_wr) begin
          d.latch[p] = sfr_wdata;  // RULE1 RULE12
        end else if (sfr_bit_wr) begin
          // Bit operations take the latch byte, not the pins, and change one bit.
          d.latch[p][sfr_bit_sel] = sfr_bit_val;  // RULE10 RULE9
        end
        // A read returns the latch for read-modify-write, the pins otherwise.
        if (sfr_rd) begin
          d.rvalid = 1'b1;
          if (sfr_rmw) begin
            d.rdata = q.latch[p];  // RULE9
          end else begin
            d.rdata = pin_in[p];  // RULE17
          end
        end
      end
    end
  end

  // State register: latches reset to ones, everything holds while ce is low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{latch: {5{`LATCH_RST}}, rdata: 8'h00, rvalid: 1'b0};  // RULE11
    end else if (ce) begin
      q <= d;  // RULE13
    end
  end

  // Read answers and latch contents come straight from flip-flops.
  assign sfr_rdata = q.rdata;
  assign sfr_rvalid = q.rvalid;
  assign latch_out = q.latch;

  // One pin cell per port; port 0 has no pull-ups, ports 0 and 2 carry the bus.
  // The cell registers its controls, so a latch written at the end of one
  // cycle reaches the pins at the end of the next.
  for (genvar p = 0; p < 5; p++) begin : g_port
    port_pin_cell #(
      .HAS_PULLUP (p != 0),
      .HAS_BUS    ((p == 0) || (p == 2))
    ) u_cell (
      .clk      (clk),
      .nrst     (nrst),
      .ce       (ce),
      .latch    (q.latch[p]),
      .alt_out  (alt_out[p]),
      .bus_en   (bus_en),
      .bus_data ((p == 0) ? bus_ad_lo : bus_addr_hi),
      .pin_in   (pin_in[p]),
      .ctrl     (pin_ctrl[p])
    );
  end

  // Right after reset every latch holds all ones.
  property p_reset_ones;
    @(posedge clk)
      $rose(nrst) |-> q.latch == {5{`LATCH_RST}};
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("latch not ones after reset"); // RULE11

  // A byte write to port 1 lands in its latch one cycle later.
  property p_byte_write;
    @(posedge clk) disable iff (!nrst)
      ce && sfr_wr && sel_w[1] |=> latch_out[1] == $past(sfr_wdata);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost"); // RULE1

  // A bit write to port 3 changes the addressed bit and no other.
  property p_bit_write;
    @(posedge clk) disable iff (!nrst)
      ce && !sfr_wr && sfr_bit_wr && sel_w[3]
      |=> (latch_out[3][$past(sfr_bit_sel)] == $past(sfr_bit_val))
          && (((latch_out[3] ^ $past(latch_out[3]))
               & ~(8'h01 << $past(sfr_bit_sel))) == 8'h00);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write disturbed latch"); // RULE10

  // A read-modify-write read of port 2 answers the latch, not the pin.
  property p_read_latch;
    @(posedge clk) disable iff (!nrst)
      ce && sfr_rd && sfr_rmw && sel_w[2]
      |=> sfr_rvalid && (sfr_rdata == $past(latch_out[2]));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read wrong"); // RULE9

  // A plain read of port 4 answers the pin level.
  property p_read_pin;
    @(posedge clk) disable iff (!nrst)
      ce && sfr_rd && !sfr_rmw && sel_w[4]
      |=> sfr_rvalid && (sfr_rdata == $past(pin_in[4]));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("pin read wrong"); // RULE17

  // Two cycles after a port 1 write with no alternate override, the pins show it.
  property p_pin_follows;
    @(posedge clk) disable iff (!nrst)
      ce && sfr_wr && sel_w[1] && alt_out[1] == 8'hFF ##1 ce && alt_out[1] == 8'hFF
      |=> pin_ctrl[1].o == $past(sfr_wdata, 2);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin not updated"); // RULE13

  // During bus cycles port 2 shows the bus, whatever the latch holds.
  property p_bus_port2;
    @(posedge clk) disable iff (!nrst)
      ce && bus_en |=> pin_ctrl[2].o == $past(bus_addr_hi);
  endproperty
  a_bus_port2: assert property (p_bus_port2) else $error("bus not on port 2"); // RULE4

  // A port 3 pin is pulled down only when its driven level is zero.
  property p_pulldown;
    @(posedge clk) disable iff (!nrst)
      1'b1 |-> ((~pin_ctrl[3].oe_n & pin_ctrl[3].o & ~pin_ctrl[3].boost) == 8'h00);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down on a one"); // RULE18

endmodule : port_latches

/* File: sim/pin_model.sv */
// Behavioural model of the pads and the outside world seen by the five ports.
`timescale 1ns/10ps

module pin_model
  import port_pkg::*;
(
  input  wire logic        clk,
  input  wire port_ctrl_t  pin_ctrl,
  input  wire port_bytes_t ext_low,
  output port_bytes_t      pin_in
);

  byte_t float_q = 8'h5A;  // Level shown by a floating port 0 pin.

  // A released port 0 pin never keeps its last level: it flips every cycle.
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Each pin is set by the strong drive, else an outside pull-low, else the pull-ups, or on port 0 the floating level.
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!pin_ctrl[p].oe_n[b]) begin
          pin_in[p][b] = pin_ctrl[p].o[b];
        end else if (ext_low[p][b]) begin
          pin_in[p][b] = 1'b0;
        end else if (p == 0) begin
          pin_in[p][b] = float_q[b];
        end else begin
          pin_in[p][b] = 1'b1;
        end
      end
    end
  end

endmodule : pin_model

/* File: sim/tb_quasi_bidir_port_latches.sv */
// Self-checking testbench of the port latch block and its pin drive.
`timescale 1ns/10ps
`include "port_defines.svh"

module tb_quasi_bidir_port_latches
  import port_pkg::*;
;

  logic        clk, nrst, ce, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw, bus_en;
  logic        sfr_rvalid, sfr_hit;
  logic [2:0]  sfr_bit_sel;
  byte_t       sfr_addr, sfr_wdata, bus_ad_lo, bus_addr_hi, sfr_rdata, m, lo, hi;
  port_bytes_t alt_out, pin_in, latch_out, ext_low, model;
  port_ctrl_t  pin_ctrl;
  int          n_errors, check_count, p;
  byte_t       adr [5] = '{`PORT_ZERO_ADDR, `PORT_ONE_ADDR, `PORT_TWO_ADDR, `PORT_THREE_ADDR, `PORT_FOUR_ADDR};

  port_latches DUT (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .sfr_hit(sfr_hit),
    .alt_out(alt_out), .bus_en(bus_en), .bus_ad_lo(bus_ad_lo), .bus_addr_hi(bus_addr_hi),
    .pin_in(pin_in), .latch_out(latch_out), .pin_ctrl(pin_ctrl));

  pin_model pads (.clk(clk), .pin_ctrl(pin_ctrl), .ext_low(ext_low), .pin_in(pin_in));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Compares one byte result.
  task automatic chk(input byte_t got, input byte_t exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Pin level seen on a released pulled-up port: high unless pulled low from outside.
  function automatic byte_t pin_exp(input byte_t lvl, input byte_t low);
    return lvl & ~low;
  endfunction : pin_exp

  // Waits n edges and steps past them so outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Byte write; returns at the edge that takes it.
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask : wr

  // Single-bit write into a latch.
  task automatic bwr(input byte_t a, input logic [2:0] s, input logic v);
    @(posedge clk);
    sfr_addr    <= a;
    sfr_bit_sel <= s;
    sfr_bit_val <= v;
    sfr_bit_wr  <= 1'b1;
    @(posedge clk);
    sfr_bit_wr  <= 1'b0;
  endtask : bwr

  // Read of latch or pins; the answer stands for the one cycle after the taking edge, and is looked at then.
  task automatic rd(input byte_t a, input logic lsel, input logic hit, input byte_t exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rmw  <= lsel;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    #1;
    chk({7'h00, sfr_rvalid}, {7'h00, hit}, "read valid");
    if (hit) chk(sfr_rdata, exp, "read data");
  endtask : rd

  // Settled drive of a port whose effective level is e, outside bus cycles.
  task automatic chk_port(input int q, input byte_t e);
    chk(pin_ctrl[q].o, e, "level");
    chk(pin_ctrl[q].oe_n, e, "pull-down");
    chk(pin_ctrl[q].boost, 8'h00, "boost idle");
    chk(pin_ctrl[q].vweak, (q == 0) ? 8'h00 : e, "very weak");
  endtask : chk_port

  // Cuts a hung run short.
  initial begin
    #800000;
    n_errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    {nrst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw, bus_en} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_sel, bus_ad_lo, bus_addr_hi, ext_low} = '0;
    ce = 1'b1;
    alt_out = '1;
    model = '1;
    void'($urandom(32'h2d53fad6));
    tick(8);
    for (p = 0; p < 5; p++) begin
      chk(latch_out[p], `LATCH_RST, "reset latch");
      chk_port(p, 8'hFF);
      chk(pin_ctrl[p].keeper, 8'h00, "reset keeper");
    end
    nrst <= 1'b1;
    // Random byte writes, then latch read-back and settled drive.
    repeat (20) begin
      p = $urandom_range(4);
      m = 8'($urandom);
      wr(adr[p], m);
      model[p] = m;
      tick(1);
      chk(latch_out[p], m, "latch");
      tick(3);
      chk_port(p, m);
      rd(adr[p], 1'b1, 1'b1, m);
    end
    // Zero then one: two boost cycles on ports 1 to 4, none on port 0, pins one cycle behind the latch.
    for (p = 0; p < 5; p++) begin
      wr(adr[p], 8'h00);
      tick(4);
      wr(adr[p], 8'hFF);
      model[p] = 8'hFF;
      tick(0);
      chk(pin_ctrl[p].o, 8'h00, "pins lag latch");
      tick(1);
      chk(pin_ctrl[p].boost, (p == 0) ? 8'h00 : 8'hFF, "boost 1");
      chk(pin_ctrl[p].oe_n, (p == 0) ? 8'hFF : 8'h00, "boost drive");
      tick(1);
      chk(pin_ctrl[p].boost, (p == 0) ? 8'h00 : 8'hFF, "boost 2");
      tick(1);
      chk_port(p, 8'hFF);
    end
    // Single-bit writes change one bit of the byte.
    repeat (16) begin
      p = $urandom_range(4);
      m = 8'($urandom);
      bwr(adr[p], m[2:0], m[7]);
      model[p][m[2:0]] = m[7];
      tick(1);
      chk(latch_out[p], model[p], "bit write");
    end
    // Outside pull-low: pin read sees it, latch read does not.
    p = 1 + $urandom_range(3);
    m = 8'($urandom);
    ext_low[p] <= m;
    wr(adr[p], 8'hFF);
    model[p] = 8'hFF;
    tick(5);
    chk(pin_ctrl[p].keeper, pin_exp(8'hFF, m), "keeper");
    rd(adr[p], 1'b0, 1'b1, pin_exp(8'hFF, m));
    rd(adr[p], 1'b1, 1'b1, 8'hFF);
    ext_low <= '0;
    // Alternate output rules a set latch; a cleared latch forces zero.
    alt_out[p] <= m;
    tick(3);
    chk_port(p, m);
    wr(adr[p], 8'h00);
    model[p] = 8'h00;
    tick(3);
    chk_port(p, 8'h00);
    alt_out <= '1;
    // Memory bus cycle takes ports 0 and 2; a latch write meanwhile is kept.
    lo = 8'($urandom);
    hi = 8'($urandom);
    bus_ad_lo <= lo;
    bus_addr_hi <= hi;
    bus_en <= 1'b1;
    m = 8'($urandom);
    wr(adr[0], m);
    model[0] = m;
    tick(2);
    chk(pin_ctrl[0].o, lo, "bus low");
    chk(pin_ctrl[0].boost, lo, "bus ones");
    chk(pin_ctrl[0].oe_n, 8'h00, "bus drive");
    chk(pin_ctrl[2].o, hi, "bus high");
    chk(pin_ctrl[2].boost, hi, "bus boost");
    chk(latch_out[0], m, "latch in bus");
    bus_en <= 1'b0;
    tick(4);
    chk_port(0, m);
    // Unmapped place and a frozen clock enable change nothing.
    wr(8'h81, 8'h00);
    rd(8'h81, 1'b1, 1'b0, 8'h00);
    chk({7'h00, sfr_hit}, 8'h00, "hit");
    ce <= 1'b0;
    wr(adr[1], ~model[1]);
    ce <= 1'b1;
    tick(1);
    for (p = 0; p < 5; p++) chk(latch_out[p], model[p], "kept");
    // A reset in mid-run loads ones again over a cleared latch.
    wr(adr[3], 8'h00);
    tick(1);
    nrst <= 1'b0;
    tick(2);
    for (p = 0; p < 5; p++) chk(latch_out[p], `LATCH_RST, "second reset");
    nrst <= 1'b1;
    tick(3);
    chk_port(3, 8'hFF);
    summarize();
  end

endmodule : tb_quasi_bidir_port_latches
